// file: hw/fpp_pkg.sv
// Purpose: Shared constants for the flash program/protect controller
// Assumes: 96 KB main array, 1 KB erase pages, 2 KB protection units
// Notes:   Offsets are byte addresses on the register port

package fpp_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [11:0] OFF_ADDR = 12'h000;
    localparam logic [11:0] OFF_DATA = 12'h004;
    localparam logic [11:0] OFF_CTRL = 12'h008;
    localparam logic [11:0] OFF_RAW = 12'h00c;
    localparam logic [11:0] OFF_MASK = 12'h010;
    localparam logic [11:0] OFF_MISC = 12'h014;
    localparam logic [11:0] OFF_READ0_ALT = 12'h130;
    localparam logic [11:0] OFF_PROG0_ALT = 12'h134;
    localparam logic [11:0] OFF_USEC = 12'h140;
    localparam logic [11:0] OFF_DBG = 12'h1d0;
    localparam logic [11:0] OFF_USER0 = 12'h1e0;
    localparam logic [11:0] OFF_USER1 = 12'h1e4;
    localparam logic [11:0] OFF_READ_BASE = 12'h200;
    localparam logic [11:0] OFF_PROG_BASE = 12'h400;

    // ----------------------------------------------------------------
    // Control word fields
    // ----------------------------------------------------------------
    localparam logic [15:0] WRITE_KEY = 16'ha442;
    localparam int KEY_LSB = 16;
    localparam int OP_WRITE = 0;
    localparam int OP_ERASE = 1;
    localparam int OP_MASS = 2;
    localparam int OP_COMMIT = 3;
    localparam int NOT_WRITTEN_BIT = 31;

    // ----------------------------------------------------------------
    // Nonvolatile word indices: 0-3 read permit, 4-7 program permit
    // ----------------------------------------------------------------
    localparam logic [3:0] IDX_PROG_BASE = 4'h4;
    localparam logic [3:0] IDX_USER0 = 4'h8;
    localparam logic [3:0] IDX_USER1 = 4'h9;
    localparam logic [3:0] IDX_DBG = 4'ha;
    localparam logic [3:0] IDX_NONE = 4'hf;
    localparam int NV_WORDS = 11;

    // Commit address codes
    localparam logic [31:0] CODE_READ1 = 32'h0000_0002;
    localparam logic [31:0] CODE_READ2 = 32'h0000_0004;
    localparam logic [31:0] CODE_READ3 = 32'h0000_0008;
    localparam logic [31:0] CODE_READ0 = 32'h0000_0000;
    localparam logic [31:0] CODE_PROG0 = 32'h0000_0001;
    localparam logic [31:0] CODE_PROG1 = 32'h0000_0003;
    localparam logic [31:0] CODE_PROG2 = 32'h0000_0005;
    localparam logic [31:0] CODE_PROG3 = 32'h0000_0007;
    localparam logic [31:0] CODE_USER0 = 32'h8000_0000;
    localparam logic [31:0] CODE_USER1 = 32'h8000_0001;
    localparam logic [31:0] CODE_DBG = 32'h7510_0000;

    // ----------------------------------------------------------------
    // Reset and factory values
    // ----------------------------------------------------------------
    localparam logic [31:0] RST_PERMIT_LO = 32'hffff_ffff;
    localparam logic [31:0] RST_PERMIT_HI = 32'h0000_ffff;
    localparam logic [31:0] RST_PERMIT_NONE = 32'h0000_0000;
    localparam logic [31:0] RST_USER = 32'hffff_ffff;
    localparam logic [31:0] RST_DBG = 32'hffff_fffe;
    localparam logic [7:0] RST_USEC_RELOAD = 8'h18;

    // ----------------------------------------------------------------
    // Operation times, in microsecond ticks
    // ----------------------------------------------------------------
    localparam int PROG_TIME_US = 50;
    localparam int PAGE_ERASE_TIME_US = 20000;
    localparam int MASS_ERASE_TIME_US = 200000;
    localparam int COMMIT_TIME_US = 50;
endpackage : fpp_pkg

// file: hw/fpp_ctrl.sv
// Purpose: Flash sequencer with block program/read protection
// Assumes: Array and nonvolatile store answer reads in the strobe cycle
// Notes:   One clock, asynchronous active-low reset

`timescale 1ns/1ps
`default_nettype none

module fpp_ctrl #(
    parameter int PROG_US = fpp_pkg::PROG_TIME_US,
    parameter int PAGE_ERASE_US = fpp_pkg::PAGE_ERASE_TIME_US,
    parameter int MASS_ERASE_US = fpp_pkg::MASS_ERASE_TIME_US,
    parameter int COMMIT_US = fpp_pkg::COMMIT_TIME_US
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register port
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Processor read/fetch port
    input wire logic acc_req,
    input wire logic acc_fetch,
    input wire logic [16:0] acc_addr,
    output logic acc_ack,
    output logic acc_denied,
    output logic [31:0] acc_rdata,
    // Main array
    output logic [16:0] fl_addr,
    output logic [31:0] fl_wdata,
    output logic fl_rd,
    output logic fl_prog,
    output logic fl_erase,
    output logic fl_mass,
    input wire logic [31:0] fl_rdata,
    // Nonvolatile word store
    output logic [3:0] nv_sel,
    output logic nv_rd,
    output logic nv_wr,
    output logic [31:0] nv_wdata,
    input wire logic [31:0] nv_rdata,
    // Factory restore and interrupt
    input wire logic restore_req,
    output logic restore_busy,
    output logic ctrl_irq
);
    typedef enum logic [2:0] {S_LOAD, S_IDLE, S_PROG, S_NV, S_PULSE, S_RESTORE} fpp_state_t;

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    // Live word index behind a register offset
    function automatic logic [3:0] reg_index(input logic [11:0] a);
        logic [3:0] r;
        r = fpp_pkg::IDX_NONE;
        if (a == fpp_pkg::OFF_READ0_ALT)
            r = 4'h0;
        else if (a == fpp_pkg::OFF_PROG0_ALT)
            r = fpp_pkg::IDX_PROG_BASE;
        else if (a == fpp_pkg::OFF_DBG)
            r = fpp_pkg::IDX_DBG;
        else if (a == fpp_pkg::OFF_USER0)
            r = fpp_pkg::IDX_USER0;
        else if (a == fpp_pkg::OFF_USER1)
            r = fpp_pkg::IDX_USER1;
        else if (a[11:4] == fpp_pkg::OFF_READ_BASE[11:4] && a[1:0] == 2'h0)
            r = {2'h0, a[3:2]};
        else if (a[11:4] == fpp_pkg::OFF_PROG_BASE[11:4] && a[1:0] == 2'h0)
            r = {2'h1, a[3:2]};
        return r;
    endfunction : reg_index

    // Permit bit of the 2 KB unit holding an address
    function automatic logic permit(input logic [31:0] lo, input logic [31:0] hi, input logic [16:0] a);
        return a[16] ? hi[a[15:11]] : lo[a[15:11]];
    endfunction : permit

    // Factory value of a nonvolatile word
    function automatic logic [31:0] factory(input logic [3:0] i);
        logic [31:0] v;
        v = fpp_pkg::RST_PERMIT_NONE;
        if (i == 4'h0 || i == fpp_pkg::IDX_PROG_BASE)
            v = fpp_pkg::RST_PERMIT_LO;
        else if (i == 4'h1 || i == 4'h5)
            v = fpp_pkg::RST_PERMIT_HI;
        else if (i == fpp_pkg::IDX_USER0 || i == fpp_pkg::IDX_USER1)
            v = fpp_pkg::RST_USER;
        else if (i == fpp_pkg::IDX_DBG)
            v = fpp_pkg::RST_DBG;
        return v;
    endfunction : factory

    // Commit address code to word index
    function automatic logic [3:0] commit_index(input logic [31:0] c);
        logic [3:0] r;
        unique case (c)
            fpp_pkg::CODE_READ0: r = 4'h0;
            fpp_pkg::CODE_READ1: r = 4'h1;
            fpp_pkg::CODE_READ2: r = 4'h2;
            fpp_pkg::CODE_READ3: r = 4'h3;
            fpp_pkg::CODE_PROG0: r = 4'h4;
            fpp_pkg::CODE_PROG1: r = 4'h5;
            fpp_pkg::CODE_PROG2: r = 4'h6;
            fpp_pkg::CODE_PROG3: r = 4'h7;
            fpp_pkg::CODE_USER0: r = fpp_pkg::IDX_USER0;
            fpp_pkg::CODE_USER1: r = fpp_pkg::IDX_USER1;
            fpp_pkg::CODE_DBG: r = fpp_pkg::IDX_DBG;
            default: r = fpp_pkg::IDX_NONE;
        endcase
        return r;
    endfunction : commit_index

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    fpp_state_t st_r;
    logic [31:0] live_r [0:fpp_pkg::NV_WORDS-1];
    logic [31:0] addr_r;
    logic [31:0] data_r;
    logic [3:0] op_r;
    logic [7:0] usec_r;
    logic [7:0] us_cnt_r;
    logic tick_r;
    logic raw_r;
    logic mask_r;
    logic done_r;
    logic viol_r;
    logic acc_busy_r;
    logic rst_pend_r;
    logic [17:0] cnt_r;
    logic [3:0] ci_r;
    logic [3:0] wi;
    logic [3:0] ri;
    logic load_we;
    logic pe_ok;
    logic rd_ok;

    assign wi = reg_index(reg_addr);
    assign ri = reg_index(reg_addr);
    assign load_we = (st_r == S_LOAD) && nv_rd;
    // Live words steer protection at once
    assign pe_ok = permit(live_r[4], live_r[5], addr_r[16:0]);
    assign rd_ok = permit(live_r[0], live_r[1], acc_addr);

    // ----------------------------------------------------------------
    // Microsecond tick
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            us_cnt_r <= 8'h00;
            tick_r <= 1'b0;
        end
        else if (us_cnt_r == 8'h00)
        begin
            us_cnt_r <= usec_r;
            tick_r <= 1'b1;
        end
        else
        begin
            us_cnt_r <= us_cnt_r - 8'h01;
            tick_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < fpp_pkg::NV_WORDS; i++)
                live_r[i] <= factory(4'(i));
            addr_r <= 32'h0000_0000;
            data_r <= 32'h0000_0000;
            op_r <= 4'h0;
            usec_r <= fpp_pkg::RST_USEC_RELOAD;
            mask_r <= 1'b0;
        end
        else
        begin
            if (load_we)
                live_r[nv_sel] <= nv_rdata;
            else if (reg_wr && wi != fpp_pkg::IDX_NONE)
                live_r[wi] <= reg_wdata;
            if (done_r)
                op_r <= 4'h0;
            else if (reg_wr && reg_addr == fpp_pkg::OFF_CTRL && op_r == 4'h0 && st_r == S_IDLE
                     && reg_wdata[31:fpp_pkg::KEY_LSB] == fpp_pkg::WRITE_KEY)
                op_r <= reg_wdata[3:0];
            if (reg_wr && reg_addr == fpp_pkg::OFF_ADDR)
                addr_r <= reg_wdata;
            if (reg_wr && reg_addr == fpp_pkg::OFF_DATA)
                data_r <= reg_wdata;
            if (reg_wr && reg_addr == fpp_pkg::OFF_USEC)
                usec_r <= reg_wdata[7:0];
            if (reg_wr && reg_addr == fpp_pkg::OFF_MASK)
                mask_r <= reg_wdata[0];
        end
    end

    // Violation flag: a new event wins over a clear
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            raw_r <= 1'b0;
            ctrl_irq <= 1'b0;
        end
        else
        begin
            if (viol_r)
                raw_r <= 1'b1;
            else if (reg_wr && reg_addr == fpp_pkg::OFF_MISC && reg_wdata[0])
                raw_r <= 1'b0;
            ctrl_irq <= raw_r & mask_r;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            reg_rdata <= 32'h0000_0000;
        else if (reg_rd)
        begin
            if (ri != fpp_pkg::IDX_NONE)
                reg_rdata <= live_r[ri];
            else if (reg_addr == fpp_pkg::OFF_ADDR)
                reg_rdata <= {15'h0000, addr_r[16:0]};
            else if (reg_addr == fpp_pkg::OFF_DATA)
                reg_rdata <= data_r;
            else if (reg_addr == fpp_pkg::OFF_CTRL)
                reg_rdata <= {28'h000_0000, op_r};
            else if (reg_addr == fpp_pkg::OFF_RAW)
                reg_rdata <= {31'h0000_0000, raw_r};
            else if (reg_addr == fpp_pkg::OFF_MASK)
                reg_rdata <= {31'h0000_0000, mask_r};
            else if (reg_addr == fpp_pkg::OFF_MISC)
                reg_rdata <= {31'h0000_0000, raw_r & mask_r};
            else if (reg_addr == fpp_pkg::OFF_USEC)
                reg_rdata <= {24'h00_0000, usec_r};
            else
                reg_rdata <= 32'h0000_0000;
        end
        else
            reg_rdata <= 32'h0000_0000;
    end

    // ----------------------------------------------------------------
    // Sequencer and array/store ports
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_r <= S_LOAD;
            fl_addr <= 17'h0_0000;
            fl_wdata <= 32'h0000_0000;
            fl_rd <= 1'b0;
            fl_prog <= 1'b0;
            fl_erase <= 1'b0;
            fl_mass <= 1'b0;
            nv_sel <= 4'h0;
            nv_rd <= 1'b0;
            nv_wr <= 1'b0;
            nv_wdata <= 32'h0000_0000;
            acc_ack <= 1'b0;
            acc_denied <= 1'b0;
            acc_rdata <= 32'h0000_0000;
            acc_busy_r <= 1'b0;
            restore_busy <= 1'b0;
            rst_pend_r <= 1'b0;
            done_r <= 1'b0;
            viol_r <= 1'b0;
            cnt_r <= 18'h0_0000;
            ci_r <= 4'h0;
        end
        else
        begin
            done_r <= 1'b0;
            viol_r <= 1'b0;
            fl_rd <= 1'b0;
            nv_rd <= 1'b0;
            acc_ack <= 1'b0;
            acc_denied <= 1'b0;
            if (restore_req)
                rst_pend_r <= 1'b1;
            if (acc_busy_r && fl_rd)
            begin
                acc_ack <= 1'b1;
                acc_rdata <= fl_rdata;
            end
            if (acc_ack)
                acc_busy_r <= 1'b0;
            unique case (st_r)
                S_LOAD:
                begin
                    nv_rd <= 1'b1;
                    if (nv_rd)
                    begin
                        if (nv_sel == fpp_pkg::IDX_DBG)
                        begin
                            nv_rd <= 1'b0;
                            nv_sel <= 4'h0;
                            st_r <= S_IDLE;
                        end
                        else
                            nv_sel <= nv_sel + 4'h1;
                    end
                end
                S_IDLE:
                begin
                    if (acc_req && !acc_busy_r && !acc_ack)
                    begin
                        if (!acc_fetch && !rd_ok)
                        begin
                            acc_ack <= 1'b1;
                            acc_denied <= 1'b1;
                            acc_rdata <= 32'h0000_0000;
                            viol_r <= 1'b1;
                        end
                        else
                        begin
                            acc_busy_r <= 1'b1;
                            fl_rd <= 1'b1;
                            fl_addr <= acc_addr;
                        end
                    end
                    else if (!acc_busy_r && rst_pend_r)
                    begin
                        rst_pend_r <= 1'b0;
                        restore_busy <= 1'b1;
                        fl_mass <= 1'b1;
                        cnt_r <= 18'(MASS_ERASE_US);
                        st_r <= S_PULSE;
                    end
                    else if (!acc_busy_r && op_r != 4'h0 && !done_r)
                    begin
                        if (op_r[fpp_pkg::OP_WRITE] || op_r[fpp_pkg::OP_ERASE])
                        begin
                            if (!pe_ok)
                            begin
                                done_r <= 1'b1;
                                viol_r <= 1'b1;
                            end
                            else if (op_r[fpp_pkg::OP_WRITE])
                            begin
                                fl_rd <= 1'b1;
                                fl_addr <= {addr_r[16:2], 2'b00};
                                st_r <= S_PROG;
                            end
                            else
                            begin
                                fl_erase <= 1'b1;
                                fl_addr <= {addr_r[16:10], 10'h000};
                                cnt_r <= 18'(PAGE_ERASE_US);
                                st_r <= S_PULSE;
                            end
                        end
                        else if (op_r[fpp_pkg::OP_MASS])
                        begin
                            fl_mass <= 1'b1;
                            cnt_r <= 18'(MASS_ERASE_US);
                            st_r <= S_PULSE;
                        end
                        else if (commit_index(addr_r) == fpp_pkg::IDX_NONE)
                            done_r <= 1'b1;
                        else
                        begin
                            ci_r <= commit_index(addr_r);
                            nv_sel <= commit_index(addr_r);
                            nv_rd <= 1'b1;
                            st_r <= S_NV;
                        end
                    end
                end
                S_PROG:
                begin
                    fl_wdata <= fl_rdata & data_r;
                    fl_prog <= 1'b1;
                    cnt_r <= 18'(PROG_US);
                    st_r <= S_PULSE;
                end
                S_NV:
                begin
                    if (ci_r >= fpp_pkg::IDX_USER0 && !nv_rdata[fpp_pkg::NOT_WRITTEN_BIT])
                    begin
                        done_r <= 1'b1;
                        st_r <= S_IDLE;
                    end
                    else
                    begin
                        nv_wr <= 1'b1;
                        if (ci_r == fpp_pkg::IDX_DBG)
                            nv_wdata <= data_r & nv_rdata & 32'h7fff_ffff;
                        else if (ci_r >= fpp_pkg::IDX_USER0)
                            nv_wdata <= live_r[ci_r] & nv_rdata & 32'h7fff_ffff;
                        else
                            nv_wdata <= live_r[ci_r] & nv_rdata;
                        cnt_r <= 18'(COMMIT_US);
                        st_r <= S_PULSE;
                    end
                end
                S_PULSE:
                begin
                    if (tick_r)
                        cnt_r <= cnt_r - 18'h0_0001;
                    if (tick_r && cnt_r == 18'h0_0001)
                    begin
                        fl_prog <= 1'b0;
                        fl_erase <= 1'b0;
                        fl_mass <= 1'b0;
                        nv_wr <= 1'b0;
                        if (!restore_busy)
                        begin
                            done_r <= 1'b1;
                            st_r <= S_IDLE;
                        end
                        else if (fl_mass)
                        begin
                            nv_sel <= 4'h0;
                            st_r <= S_RESTORE;
                        end
                        else if (nv_sel == fpp_pkg::IDX_DBG)
                        begin
                            restore_busy <= 1'b0;
                            nv_sel <= 4'h0;
                            st_r <= S_LOAD;
                        end
                        else
                        begin
                            nv_sel <= nv_sel + 4'h1;
                            st_r <= S_RESTORE;
                        end
                    end
                end
                S_RESTORE:
                begin
                    nv_wdata <= factory(nv_sel);
                    nv_wr <= 1'b1;
                    cnt_r <= 18'(COMMIT_US);
                    st_r <= S_PULSE;
                end
            endcase
        end
    end
endmodule : fpp_ctrl

`default_nettype wire

// file: verif/fpp_ctrl_sva.sv
// Purpose: Port assertions for the flash sequencer
// Assumes: Bound to fpp_ctrl
// Notes:   Restore traffic is left out of commit checks
`timescale 1ns/1ps
`default_nettype none
module fpp_ctrl_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Processor port
    input wire logic acc_ack,
    input wire logic acc_denied,
    input wire logic [31:0] acc_rdata,
    // Array and store
    input wire logic fl_rd,
    input wire logic [31:0] fl_rdata,
    input wire logic [31:0] fl_wdata,
    input wire logic fl_prog,
    input wire logic fl_erase,
    input wire logic fl_mass,
    input wire logic [3:0] nv_sel,
    input wire logic nv_wr,
    input wire logic [31:0] nv_wdata,
    input wire logic [31:0] nv_rdata,
    input wire logic restore_busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_ack_pulse: assert property (acc_ack |=> !acc_ack) else $error("long ack");
    a_denied_zeros: assert property (acc_denied |-> acc_ack && acc_rdata == 0) else $error("denied data");
    a_grant_data: assert property (acc_ack && !acc_denied |-> $past(fl_rd) && acc_rdata == $past(fl_rdata))
        else $error("granted data");
    a_prog_clears: assert property ($rose(fl_prog) |-> $past(fl_rd) && (fl_wdata & ~$past(fl_rdata)) == 0)
        else $error("program sets bits");
    a_one_op: assert property ($onehot0({fl_prog, fl_erase, fl_mass})) else $error("ops overlap");
    a_erase_keeps_nv: assert property (fl_erase || fl_mass |-> !nv_wr) else $error("erase hits store");
    a_nv_clears: assert property ($rose(nv_wr) && !restore_busy |-> (nv_wdata & ~$past(nv_rdata)) == 0)
        else $error("commit sets bits");
    a_once_used: assert property ($rose(nv_wr) && nv_sel >= 4'h8 && !restore_busy |-> !nv_wdata[31])
        else $error("once flag kept");
endmodule : fpp_ctrl_sva
bind fpp_ctrl fpp_ctrl_sva u_sva (.clk, .rst_b, .acc_ack, .acc_denied, .acc_rdata, .fl_rd, .fl_rdata, .fl_wdata,
    .fl_prog, .fl_erase, .fl_mass, .nv_sel, .nv_wr, .nv_wdata, .nv_rdata, .restore_busy);
`default_nettype wire

// file: verif/fpp_flash_model.sv
// Purpose: Behavioural flash array and nonvolatile word store
// Assumes: Reads answer in the strobe cycle
// Notes:   Store keeps its contents across resets
`timescale 1ns/1ps
`default_nettype none
module fpp_flash_model (
    // Clock
    input wire logic clk,
    // Main array
    input wire logic [16:0] fl_addr,
    input wire logic [31:0] fl_wdata,
    input wire logic fl_rd,
    input wire logic fl_prog,
    input wire logic fl_erase,
    input wire logic fl_mass,
    output logic [31:0] fl_rdata,
    // Nonvolatile store
    input wire logic [3:0] nv_sel,
    input wire logic nv_rd,
    input wire logic nv_wr,
    input wire logic [31:0] nv_wdata,
    output logic [31:0] nv_rdata
);
    logic [31:0] mem [0:32767];
    logic [31:0] nv [0:15];
    initial
    begin
        foreach (mem[i]) mem[i] = 32'hffff_ffff;
        foreach (nv[i]) nv[i] = i > 9 ? fpp_pkg::RST_DBG : i > 7 ? fpp_pkg::RST_USER : i % 4 == 0 ?
            fpp_pkg::RST_PERMIT_LO : i % 4 == 1 ? fpp_pkg::RST_PERMIT_HI : fpp_pkg::RST_PERMIT_NONE;
    end
    // Unselected lines show the inverse word
    assign fl_rdata = fl_rd ? mem[fl_addr[16:2]] : ~mem[fl_addr[16:2]];
    assign nv_rdata = nv_rd ? nv[nv_sel] : ~nv[nv_sel];
    always @(posedge clk)
    begin
        if (fl_prog) mem[fl_addr[16:2]] <= mem[fl_addr[16:2]] & fl_wdata;
        if (fl_erase) for (int i = 0; i < 256; i++) mem[{fl_addr[16:10], i[7:0]}] <= 32'hffff_ffff;
        if (fl_mass) foreach (mem[i]) mem[i] <= 32'hffff_ffff;
        if (nv_wr) nv[nv_sel] <= nv_wdata;
    end
endmodule : fpp_flash_model
`default_nettype wire

// file: verif/fpp_ctrl_tb_top.sv
// Purpose: Self-checking bench for the flash sequencer
// Assumes: Short operation times, reload 0 after setup
// Notes:   Checked register reads and all processor reads queue their expected value
`timescale 1ns/1ps
`default_nettype none
module fpp_ctrl_tb_top;
    logic clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, acc_req = 0, acc_fetch = 0, rd_d = 0, restore_req = 0, busy, irq;
    logic [11:0] reg_addr = '0;
    logic [16:0] acc_addr = '0, fl_addr;
    logic [31:0] reg_wdata = '0, d, e, reg_rdata, acc_rdata, fl_rdata, fl_wdata, nv_rdata, nv_wdata, q[$];
    logic [3:0] nv_sel;
    logic acc_ack, acc_denied, fl_rd, fl_prog, fl_erase, fl_mass, nv_rd, nv_wr;
    int failures = 0, cmp_count = 0, seed = 32'h0866;
    always #50 clk = ~clk;
    fpp_ctrl #(.PROG_US(2), .PAGE_ERASE_US(3), .MASS_ERASE_US(3), .COMMIT_US(2)) dut (.clk, .rst_b, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .acc_req, .acc_fetch, .acc_addr, .acc_ack, .acc_denied, .acc_rdata,
        .fl_addr, .fl_wdata, .fl_rd, .fl_prog, .fl_erase, .fl_mass, .fl_rdata, .nv_sel, .nv_rd, .nv_wr, .nv_wdata,
        .nv_rdata, .restore_req, .restore_busy(busy), .ctrl_irq(irq));
    fpp_flash_model u_flash (.clk, .fl_addr, .fl_wdata, .fl_rd, .fl_prog, .fl_erase, .fl_mass, .fl_rdata, .nv_sel,
        .nv_rd, .nv_wr, .nv_wdata, .nv_rdata);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected read data: expected %h seen %h", exp, seen);
        end
    endtask : check
    always @(posedge clk)
    begin
        if ((rd_d || acc_ack) && q.size() > 0) check(rd_d ? reg_rdata : acc_rdata, q.pop_front());
        rd_d <= reg_rd;
    end
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] v, input logic c);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        if (c) q.push_back(v);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask : rd
    task automatic go(input logic [31:0] v);
        wr(fpp_pkg::OFF_CTRL, v);
        repeat (100)
        begin
            rd(fpp_pkg::OFF_CTRL, '0, 1'b0);
            @(posedge clk);
            if (reg_rdata[3:0] === 4'h0) break;
        end
        rd(fpp_pkg::OFF_CTRL, '0, 1'b1);
    endtask : go
    task automatic acc(input logic [16:0] a, input logic f, input logic [31:0] v);
        @(posedge clk);
        acc_req <= 1'b1;
        acc_fetch <= f;
        acc_addr <= a;
        q.push_back(v);
        do @(posedge clk); while (acc_ack !== 1'b1);
        acc_req <= 1'b0;
    endtask : acc
    task automatic give_verdict;
        if (failures == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict
    initial
    begin
        #2000000;
        failures++;
        give_verdict();
    end
    initial
    begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (20) @(posedge clk);
        rd(fpp_pkg::OFF_USEC, 32'h0000_0018, 1'b1);
        rd(fpp_pkg::OFF_READ_BASE + 12'h004, fpp_pkg::RST_PERMIT_HI, 1'b1);
        rd(12'hffc, 32'h0, 1'b1);
        wr(fpp_pkg::OFF_USEC, 32'h0);
        d = $random(seed);
        e = $random(seed);
        wr(fpp_pkg::OFF_DATA, d);
        wr(fpp_pkg::OFF_ADDR, 32'h10);
        go(32'ha442_0001);
        acc(17'h00010, 1'b1, d);
        wr(fpp_pkg::OFF_DATA, e);
        go(32'ha442_0001);
        acc(17'h00010, 1'b0, d & e);
        wr(fpp_pkg::OFF_ADDR, 32'h0);
        go(32'ha442_0002);
        acc(17'h00010, 1'b0, 32'hffff_ffff);
        wr(fpp_pkg::OFF_DATA, 32'h0);
        go(32'h1234_0001);
        acc(17'h00000, 1'b0, 32'hffff_ffff);
        wr(fpp_pkg::OFF_PROG_BASE, 32'hffff_fffe);
        go(32'ha442_0001);
        acc(17'h00000, 1'b0, 32'hffff_ffff);
        rd(fpp_pkg::OFF_RAW, 32'h1, 1'b1);
        wr(fpp_pkg::OFF_READ_BASE, 32'hffff_fffe);
        acc(17'h00000, 1'b0, 32'h0);
        acc(17'h00000, 1'b1, 32'hffff_ffff);
        wr(fpp_pkg::OFF_ADDR, fpp_pkg::CODE_PROG0);
        go(32'ha442_0008);
        wr(fpp_pkg::OFF_ADDR, fpp_pkg::CODE_USER0);
        go(32'ha442_0008);
        wr(fpp_pkg::OFF_ADDR, 32'h800);
        go(32'ha442_0001);
        go(32'ha442_0004);
        acc(17'h00800, 1'b1, 32'hffff_ffff);
        wr(fpp_pkg::OFF_MASK, 32'h1);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h1);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (20) @(posedge clk);
        rd(fpp_pkg::OFF_READ_BASE, fpp_pkg::RST_PERMIT_LO, 1'b1);
        restore_req <= 1'b1;
        @(posedge clk);
        restore_req <= 1'b0;
        repeat (3) @(posedge clk);
        check({31'h0, busy}, 32'h1);
        while (busy) @(posedge clk);
        repeat (20) @(posedge clk);
        rd(fpp_pkg::OFF_PROG_BASE, fpp_pkg::RST_PERMIT_LO, 1'b1);
        give_verdict();
    end
endmodule : fpp_ctrl_tb_top
`default_nettype wire
